// file: common/pitc_pkg.sv
`default_nettype none
// Shared constants for the priority interrupt and trap controller
package pitc_pkg;
    // Source counts
    localparam int NSRC = 29;
    localparam int NTRAP = 4;
    localparam int NEXT = 3;
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;   // Three request flag words
    localparam logic [7:0] OFS_EN = 8'h0c;      // Three enable words
    localparam logic [7:0] OFS_PRIO = 8'h18;    // Twelve priority words
    localparam logic [7:0] OFS_CTRL1 = 8'h48;
    localparam logic [7:0] OFS_CTRL2 = 8'h4c;
    localparam logic [7:0] OFS_LEVEL = 8'h50;
    localparam logic [7:0] OFS_WIN = 8'h54;
    localparam logic [7:0] OFS_VSTAT = 8'h58;
    localparam logic [7:0] OFS_RCAUSE = 8'h5c;
    localparam logic [3:0] N_FLAG_REGS = 4'h3;
    localparam logic [3:0] N_PRIO_REGS = 4'hc;
    // Field positions
    localparam int CTRL1_NST_BIT = 15;
    localparam int CTRL1_OVA_EN_BIT = 8;
    localparam int CTRL1_COV_EN_BIT = 9;
    localparam int CTRL2_ALT_BIT = 15;
    localparam int CTRL2_WIN_BIT = 14;
    localparam int VSTAT_REQ_BIT = 15;
    // Trap indices, lowest priority first
    localparam int TRAP_MATH = 0;
    localparam int TRAP_STACK = 1;
    localparam int TRAP_ADDR = 2;
    localparam int TRAP_OSC = 3;
    localparam logic [3:0] TRAP_LVL_BASE = 4'hb;   // Math 11 up to osc 14
    localparam logic [5:0] TRAP_VEC_BASE = 6'h01;
    localparam logic [5:0] IRQ_VEC_BASE = 6'h08;
    // Reset cause bits
    localparam int RC_WDT = 0;
    localparam int RC_UWR = 1;
    localparam int RC_ILL = 2;
    localparam int RC_BRN = 3;
    localparam int RC_LOCK = 4;
    // Vector space and reset values
    localparam logic [23:0] PVT_BASE = 24'h000004;
    localparam logic [23:0] AVT_BASE = 24'h000084;
    localparam logic [23:0] VEC_SPACE_LO = 24'h000004;
    localparam logic [23:0] VEC_SPACE_HI = 24'h0000fe;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [3:0] LEVEL_RST = 4'h0;
    localparam logic [3:0] LEVEL_TOP_MASKABLE = 4'h7;
    localparam logic [2:0] PRIO_WIN_PASS = 3'h7;
    localparam int WIN_W = 14;
    localparam logic [47:0] SRC_MASK = 48'h00001fffffff;
    localparam logic [191:0] PRIO_MASK = {76'h0, {29{4'h7}}};
    // Bus handshake states
    typedef enum logic [1:0] {
        PITC_BUS_IDLE = 2'b01,
        PITC_BUS_RESP = 2'b10
    } pitc_bus_t;
endpackage : pitc_pkg
`default_nettype wire

// file: hw/pitc_pick.sv
`timescale 1ns/100ps
`default_nettype none
// Highest-priority eligible source, lowest index on a tie
module pitc_pick (
    // Eligible sources and their priorities
    input wire logic [pitc_pkg::NSRC-1:0] cand,
    input wire logic [3*pitc_pkg::NSRC-1:0] prio,
    // Winner
    output logic found,
    output logic [4:0] idx,
    output logic [2:0] lvl
);
    import pitc_pkg::*;

    // Scan from top so lower indices overwrite equal levels
    always_comb begin
        found = 1'b0;
        idx = 5'h00;
        lvl = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (cand[i] && (!found || prio[3*i +: 3] >= lvl)) begin
                found = 1'b1;
                idx = 5'(i);
                lvl = prio[3*i +: 3];
            end
        end
    end
endmodule : pitc_pick
`default_nettype wire

// file: hw/pitc_top.sv
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Arbitrate 29 sources and 4 traps
// - Hardware sets flags, software clears them
// - Flags set regardless of enable bit
// - Per-source enable gates forwarding
// - Source priority 1 to 7, 7 highest
// - Priority zero means never serviced
// - Four-bit CPU priority level
// - Nesting disable blocks new interrupts
// - Level writes ignored under nesting disable
// - Disable window blocks levels six and below
// - Vector address from 62-entry table
// - Vector space fetch raises address trap
// - Control 2 picks edges, alternate table
// - Reset forces program address zero
// - Listed faults request device reset
// - Flushed illegal opcode causes nothing
// - Traps non-maskable at levels 8-15; here traps sit at 11-14 and wait while the CPU level is at or above them
// - Level 7 masks interrupts, not traps
// - Trap waits for instruction completion
// - Higher trap pre-empts running trap
// - Divide by zero, oversize shift trap
// - Enabled accumulator overflows trap
module pitc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Request sources
    input wire logic [pitc_pkg::NSRC-1:0] periph_req,
    input wire logic [pitc_pkg::NEXT-1:0] ext_int,
    // Trap causes
    input wire logic osc_fail,
    input wire logic stack_err,
    input wire logic div_zero,
    input wire logic shift_oversize,
    input wire logic acc_ovf31,
    input wire logic acc_guard_used,
    input wire logic acc_ovf39,
    input wire logic acc_sat_en,
    // Core execution status
    input wire logic fetch_valid,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_is_vector,
    input wire logic instr_boundary,
    input wire logic instr_retire,
    input wire logic instr_illegal,
    input wire logic instr_flushed,
    input wire logic uninit_wreg,
    // Reset causes
    input wire logic wdt_timeout,
    input wire logic brownout_reset,
    // Core handshake
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic [3:0] ret_level,
    output logic irq_req,
    output logic [5:0] irq_vector,
    output logic [23:0] irq_vec_addr,
    output logic [3:0] irq_level,
    output logic [3:0] cpu_priority_level,
    output logic dev_reset_req
);
    import pitc_pkg::*;

    // Whole controller state
    typedef struct packed {
        pitc_bus_t bus;               // Bus handshake state
        logic wait_n;                 // Waitrequest level
        logic [31:0] rdata;           // Read data
        logic [47:0] flags;           // Request flags
        logic [47:0] en;              // Request enables
        logic [191:0] prio;           // Priority nibbles
        logic nesting_disable;        // No nesting
        logic ova_en;                 // Overflow 31 trap enable
        logic cov_en;                 // Overflow 39 trap enable
        logic [3:0] trap_st;          // Sticky trap status
        logic [3:0] trap_pend;        // Trap waiting
        logic [3:0] trap_arm;         // Trap after boundary
        logic alt_table;              // Alternate vector table
        logic [2:0] ext_pol;          // Edge select per pin
        logic [2:0] ext_prev;         // Previous pin levels
        logic [3:0] level;            // Current CPU level
        logic [WIN_W-1:0] win_cnt;    // Disable window count
        logic [3:0] depth;            // Services in progress
        logic req;                    // Request to core
        logic req_trap;               // Request is a trap
        logic [1:0] req_tidx;         // Trap index of request
        logic [5:0] vec;              // Presented vector
        logic [23:0] vaddr;           // Presented vector address
        logic [3:0] plevel;           // Level taken on ack
        logic rst_req;                // Device reset pulse
        logic [4:0] rcause;           // Sticky reset causes
    } pitc_state_t;

    pitc_state_t s_r;     // Registered state
    pitc_state_t s_nxt;   // Next state

    // Combinational helpers
    logic [2:0] ext_evt;
    logic [47:0] src_evt;
    logic [3:0] trap_evt;
    logic [4:0] rc_evt;
    logic [NSRC-1:0] cand;
    logic [3*NSRC-1:0] prio3;
    logic pk_found;
    logic [4:0] pk_idx;
    logic [2:0] pk_lvl;
    logic tp_found;
    logic [1:0] tp_idx;
    logic [3:0] tp_lvl;
    logic wr_en;
    logic [15:0] wr16;
    logic [3:0] wk;

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // Address is an aligned word inside a register group
    function automatic logic in_grp(input logic [7:0] a, input logic [7:0] base, input logic [3:0] n);
        in_grp = (a >= base) && (a < 8'(base + {2'b00, n, 2'b00})) && (a[1:0] == 2'b00);
    endfunction : in_grp

    // Word index inside a register group
    function automatic logic [3:0] grp_idx(input logic [7:0] a, input logic [7:0] base);
        grp_idx = 4'(8'(a - base) >> 2);
    endfunction : grp_idx

    // Vector address in the selected table
    function automatic logic [23:0] vec_addr(input logic alt, input logic [5:0] v);
        vec_addr = 24'((alt ? AVT_BASE : PVT_BASE) + {17'h0, v, 1'b0});
    endfunction : vec_addr

    // Register read mux
    function automatic logic [31:0] rd_mux(input pitc_state_t s, input logic [7:0] a);
        logic [3:0] k;
        k = 4'h0;
        rd_mux = 32'h0;
        if (in_grp(a, OFS_FLAGS, N_FLAG_REGS)) begin
            k = grp_idx(a, OFS_FLAGS);
            rd_mux = {16'h0, s.flags[16*k +: 16]};
        end else if (in_grp(a, OFS_EN, N_FLAG_REGS)) begin
            k = grp_idx(a, OFS_EN);
            rd_mux = {16'h0, s.en[16*k +: 16]};
        end else if (in_grp(a, OFS_PRIO, N_PRIO_REGS)) begin
            k = grp_idx(a, OFS_PRIO);
            rd_mux = {16'h0, s.prio[16*k +: 16]};
        end else begin
            case (a)
                OFS_CTRL1: rd_mux = {16'h0, s.nesting_disable, 5'h0, s.cov_en, s.ova_en, 4'h0, s.trap_st};
                OFS_CTRL2: rd_mux = {16'h0, s.alt_table, (s.win_cnt != '0), 11'h0, s.ext_pol};
                OFS_LEVEL: rd_mux = {28'h0, s.level};
                OFS_WIN: rd_mux = {18'h0, s.win_cnt};
                OFS_VSTAT: rd_mux = {16'h0, s.req, 3'h0, s.plevel, 2'h0, s.vec};
                OFS_RCAUSE: rd_mux = {27'h0, s.rcause};
                // Unmapped offsets read zero
                default: rd_mux = 32'h0;
            endcase
        end
    endfunction : rd_mux

    // Source eligibility against enables, priority and level
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            prio3[3*i +: 3] = s_r.prio[4*i +: 3];
            cand[i] = s_r.flags[i] && s_r.en[i]
                && (prio3[3*i +: 3] != 3'h0)
                && ({1'b0, prio3[3*i +: 3]} > s_r.level)
                && (!s_r.nesting_disable || s_r.depth == 4'h0)
                && ((s_r.win_cnt == '0) || prio3[3*i +: 3] == PRIO_WIN_PASS);
        end
    end

    // Interrupt winner
    pitc_pick u_pick (
        .cand(cand),
        .prio(prio3),
        .found(pk_found),
        .idx(pk_idx),
        .lvl(pk_lvl)
    );

    // Highest armed trap above current level, ignoring masks
    always_comb begin
        tp_found = 1'b0;
        tp_idx = 2'h0;
        tp_lvl = 4'h0;
        for (int t = 0; t < NTRAP; t++) begin
            if (s_r.trap_arm[t] && 4'(TRAP_LVL_BASE + 4'(t)) > s_r.level) begin
                tp_found = 1'b1;
                tp_idx = 2'(t);
                tp_lvl = 4'(TRAP_LVL_BASE + 4'(t));
            end
        end
    end

    // Event detection
    always_comb begin
        // Edge select per external pin
        for (int e = 0; e < NEXT; e++) begin
            ext_evt[e] = s_r.ext_pol[e] ? (s_r.ext_prev[e] && !ext_int[e])
                                        : (!s_r.ext_prev[e] && ext_int[e]);
        end
        src_evt = {19'h0, periph_req[NSRC-1:NEXT], ext_evt};
        trap_evt[TRAP_MATH] = div_zero || shift_oversize
            || (acc_ovf31 && !acc_guard_used && s_r.ova_en)
            || (acc_ovf39 && !acc_sat_en && s_r.cov_en);
        trap_evt[TRAP_STACK] = stack_err;
        trap_evt[TRAP_ADDR] = fetch_valid && !fetch_is_vector
            && fetch_addr >= VEC_SPACE_LO && fetch_addr <= VEC_SPACE_HI;
        trap_evt[TRAP_OSC] = osc_fail;
        rc_evt[RC_WDT] = wdt_timeout;
        rc_evt[RC_UWR] = uninit_wreg;
        rc_evt[RC_ILL] = instr_illegal && !instr_flushed;
        rc_evt[RC_BRN] = brownout_reset;
        rc_evt[RC_LOCK] = (trap_evt & 4'(trap_evt - 4'h1)) != 4'h0;
    end

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        wr_en = 1'b0;
        wr16 = 16'h0;
        wk = 4'h0;
        s_nxt.ext_prev = ext_int;
        // Bus handshake: one wait cycle, then answer
        case (s_r.bus)
            PITC_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    s_nxt.bus = PITC_BUS_RESP;
                    s_nxt.wait_n = 1'b0;
                    s_nxt.rdata = avs_read ? rd_mux(s_r, avs_address) : 32'h0;
                end
            end
            PITC_BUS_RESP: begin
                s_nxt.bus = PITC_BUS_IDLE;
                s_nxt.wait_n = 1'b1;
                wr_en = avs_write;
            end
            default: begin
                s_nxt.bus = PITC_BUS_IDLE;
                s_nxt.wait_n = 1'b1;
            end
        endcase
        // Register writes
        if (wr_en) begin
            if (in_grp(avs_address, OFS_FLAGS, N_FLAG_REGS)) begin
                wk = grp_idx(avs_address, OFS_FLAGS);
                s_nxt.flags[16*wk +: 16] = merge16(s_r.flags[16*wk +: 16], avs_writedata, avs_byteenable);
            end else if (in_grp(avs_address, OFS_EN, N_FLAG_REGS)) begin
                wk = grp_idx(avs_address, OFS_EN);
                s_nxt.en[16*wk +: 16] = merge16(s_r.en[16*wk +: 16], avs_writedata, avs_byteenable);
            end else if (in_grp(avs_address, OFS_PRIO, N_PRIO_REGS)) begin
                wk = grp_idx(avs_address, OFS_PRIO);
                s_nxt.prio[16*wk +: 16] = merge16(s_r.prio[16*wk +: 16], avs_writedata, avs_byteenable);
            end else begin
                case (avs_address)
                    OFS_CTRL1: begin
                        wr16 = merge16(16'(rd_mux(s_r, OFS_CTRL1)), avs_writedata, avs_byteenable);
                        s_nxt.nesting_disable = wr16[CTRL1_NST_BIT];
                        s_nxt.ova_en = wr16[CTRL1_OVA_EN_BIT];
                        s_nxt.cov_en = wr16[CTRL1_COV_EN_BIT];
                        s_nxt.trap_st = wr16[NTRAP-1:0];
                    end
                    OFS_CTRL2: begin
                        wr16 = merge16(16'(rd_mux(s_r, OFS_CTRL2)), avs_writedata, avs_byteenable);
                        s_nxt.alt_table = wr16[CTRL2_ALT_BIT];
                        s_nxt.ext_pol = wr16[NEXT-1:0];
                    end
                    OFS_LEVEL: begin
                        // Level is read-only while nesting is off
                        if (!s_r.nesting_disable && avs_byteenable[0]) begin
                            s_nxt.level = avs_writedata[3:0];
                        end
                    end
                    OFS_WIN: begin
                        s_nxt.win_cnt = WIN_W'(merge16({2'b00, s_r.win_cnt}, avs_writedata,
                                                       avs_byteenable));
                    end
                    OFS_RCAUSE: begin
                        s_nxt.rcause = 5'(merge16({11'h0, s_r.rcause}, avs_writedata, avs_byteenable));
                    end
                    // Read-only and unmapped offsets ignore writes
                    default: begin
                    end
                endcase
            end
        end
        s_nxt.flags = s_nxt.flags & SRC_MASK;
        s_nxt.en = s_nxt.en & SRC_MASK;
        s_nxt.prio = s_nxt.prio & PRIO_MASK;
        // Hardware sets win over a software clear
        s_nxt.flags = s_nxt.flags | src_evt;
        s_nxt.trap_st = s_nxt.trap_st | trap_evt;
        s_nxt.rcause = s_nxt.rcause | rc_evt;
        s_nxt.rst_req = rc_evt != 5'h0;
        // Disable window counts retired instructions
        if (!(wr_en && avs_address == OFS_WIN) && instr_retire && s_r.win_cnt != '0) begin
            s_nxt.win_cnt = WIN_W'(s_r.win_cnt - 1'b1);
        end
        // Trap arms only after the faulting instruction completes
        s_nxt.trap_pend = s_r.trap_pend | trap_evt;
        s_nxt.trap_arm = s_r.trap_arm | (s_r.trap_pend & {NTRAP{instr_boundary}});
        // Core takes the presented request
        if (irq_ack && s_r.req) begin
            s_nxt.level = s_r.plevel;
            s_nxt.depth = 4'(s_r.depth + 4'h1);
            if (s_r.req_trap) begin
                s_nxt.trap_pend[s_r.req_tidx] = trap_evt[s_r.req_tidx];
                s_nxt.trap_arm[s_r.req_tidx] = 1'b0;
            end
            s_nxt.req = 1'b0;
        end else begin
            // Return restores the level the core saved
            if (irq_return) begin
                s_nxt.level = ret_level;
                if (s_r.depth != 4'h0) begin
                    s_nxt.depth = 4'(s_r.depth - 4'h1);
                end
            end
            // Traps outrank every maskable source
            s_nxt.req = (tp_found || pk_found) && !irq_return;
            s_nxt.req_trap = tp_found;
            s_nxt.req_tidx = tp_idx;
            if (tp_found) begin
                s_nxt.vec = 6'(TRAP_VEC_BASE + {4'h0, tp_idx});
                s_nxt.plevel = tp_lvl;
            end else begin
                s_nxt.vec = 6'(IRQ_VEC_BASE + {1'b0, pk_idx});
                s_nxt.plevel = {1'b0, pk_lvl};
            end
            s_nxt.vaddr = vec_addr(s_r.alt_table, s_nxt.vec);
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.bus <= PITC_BUS_IDLE;
            s_r.wait_n <= 1'b1;
            s_r.level <= LEVEL_RST;
            s_r.vaddr <= RESET_ADDR;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops
    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.wait_n;
    assign irq_req = s_r.req;
    assign irq_vector = s_r.vec;
    assign irq_vec_addr = s_r.vaddr;
    assign irq_level = s_r.plevel;
    assign cpu_priority_level = s_r.level;
    assign dev_reset_req = s_r.rst_req;
endmodule : pitc_top
`default_nettype wire

// file: tb/pitc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Checks bus handshake and core request outputs
module pitc_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Core side
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [5:0] irq_vector,
    input wire logic [23:0] irq_vec_addr,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] cpu_priority_level,
    input wire logic dev_reset_req
);
    import pitc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Handshake steps
    sequence s_ask; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_answer; !avs_waitrequest; endsequence
    sequence s_take; irq_req && irq_ack; endsequence
    chk_bus_answer: assert property (s_ask |=> s_answer)
        else $error("no bus answer after one wait cycle");
    chk_wait_single: assert property (s_answer |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_read_upper: assert property (s_answer |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    chk_reset_clear: assert property (
        disable iff (1'b0) !rst_b |=> !irq_req && !dev_reset_req && irq_vec_addr == RESET_ADDR)
        else $error("outputs not cleared by reset");
    chk_vector_addr: assert property (irq_req |-> irq_vec_addr == PVT_BASE + {irq_vector, 1'b0}
        || irq_vec_addr == AVT_BASE + {irq_vector, 1'b0}) else $error("vector address wrong");
    chk_trap_level: assert property (irq_req && irq_vector inside {[1:4]} |->
        irq_level == TRAP_LVL_BASE + irq_vector[3:0] - 4'h1 && irq_level > cpu_priority_level)
        else $error("trap level wrong");
    chk_irq_above: assert property (irq_req && irq_vector >= IRQ_VEC_BASE |->
        cpu_priority_level < LEVEL_TOP_MASKABLE && irq_level > cpu_priority_level && irq_vector <= 6'd36)
        else $error("interrupt presented at or below level");
    chk_ack_take: assert property (s_take |=> !irq_req && cpu_priority_level == $past(irq_level))
        else $error("taken request did not set the level");
endmodule : pitc_monitor
bind pitc_top pitc_monitor u_mon (.clk, .rst_b, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .irq_ack, .irq_req, .irq_vector, .irq_vec_addr, .irq_level, .cpu_priority_level, .dev_reset_req);
`default_nettype wire

// file: tb/pitc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core side: takes a request, runs a fixed handler, then returns
module pitc_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controller side
    input wire logic irq_req,
    input wire logic [3:0] cpu_priority_level,
    output logic irq_ack,
    output logic irq_return,
    output logic [3:0] ret_level
);
    logic [5:0] hold_r; // Handler cycles left
    // One-cycle ack; saved level comes back with the return pulse
    always_ff @(posedge clk) begin
        irq_ack <= 1'b0;
        irq_return <= (hold_r == 6'h1);
        hold_r <= hold_r - {5'h0, hold_r != 6'h0};
        if (!rst_b) begin
            hold_r <= 6'h0;
            ret_level <= 4'h0;
        end else if (irq_req && hold_r == 6'h0 && !irq_return) begin
            irq_ack <= 1'b1;
            ret_level <= cpu_priority_level;
            hold_r <= 6'd40;
        end
    end
endmodule : pitc_core_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Bus and core request scenarios
module testbench;
    import pitc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0; // Held low at start
    logic [7:0] avs_address = 8'h0; // Bus master side
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, got;
    logic [28:0] periph_req = 29'h0; // Peripheral events
    logic [19:0] ev = 20'h0; // Trap, status, reset cause and external pin inputs
    logic [23:0] fetch_addr = 24'h000010; // Inside vector space
    logic avs_waitrequest, irq_ack, irq_return, irq_req, dev_reset_req;
    logic [3:0] ret_level, irq_level, cpu_priority_level;
    logic [5:0] irq_vector;
    logic [23:0] irq_vec_addr;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    pitc_top dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h3),
        .avs_readdata, .avs_waitrequest, .periph_req, .ext_int(ev[19:17]), .osc_fail(ev[0]), .stack_err(ev[1]),
        .div_zero(ev[2]), .shift_oversize(ev[3]), .acc_ovf31(ev[4]), .acc_guard_used(ev[5]), .acc_ovf39(ev[6]),
        .acc_sat_en(ev[7]), .fetch_valid(ev[8]), .fetch_addr, .fetch_is_vector(ev[9]), .instr_boundary(ev[10]),
        .instr_retire(ev[11]), .instr_illegal(ev[12]), .instr_flushed(ev[13]), .uninit_wreg(ev[14]),
        .wdt_timeout(ev[15]), .brownout_reset(ev[16]), .irq_ack, .irq_return, .ret_level, .irq_req, .irq_vector,
        .irq_vec_addr, .irq_level, .cpu_priority_level, .dev_reset_req);
    pitc_core_model core (.clk, .rst_b, .irq_req, .cpu_priority_level, .irq_ack, .irq_return, .ret_level);
    initial begin
        forever #20 clk = ~clk;
    end
    // Hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            results();
        end
    end
    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (act !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, act, exp);
        end
    endtask : check
    // One Avalon access; holds until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        got = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] d);
        bus(1'b0, a, 16'h0);
        check(got, {16'h0, d});
    endtask : rd_chk
    // One-cycle event pulse
    task automatic pulse(input logic [19:0] m, input logic [28:0] p);
        @(posedge clk);
        ev <= ev | m;
        periph_req <= p;
        @(posedge clk);
        ev <= ev & ~m;
        periph_req <= 29'h0;
    endtask : pulse
    task automatic wait_req(input logic [10:0] exp, input logic [23:0] va);
        for (int n = 0; n < 80 && irq_req !== 1'b1; n++) @(negedge clk);
        check({irq_req, irq_level, irq_vector}, exp);
        check(irq_vec_addr, va);
    endtask : wait_req
    task automatic wait_lvl(input logic [3:0] lvl);
        for (int n = 0; n < 80 && cpu_priority_level !== lvl; n++) @(negedge clk);
        check(cpu_priority_level, lvl);
    endtask : wait_lvl
    task automatic quiet;
        repeat (12) begin
            @(negedge clk);
            check(irq_req, 1'b0);
        end
    endtask : quiet
    task automatic results;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(OFS_CTRL1, 16'h0);
        rd_chk(OFS_LEVEL, 16'h0);
        bus(1'b1, 8'h60, 16'hffff);
        rd_chk(8'h60, 16'h0);
        rd_chk(8'h4e, 16'h0);
        $display("test map done");
        pulse(20'h0, 29'h20);
        rd_chk(OFS_FLAGS, 16'h0020);
        bus(1'b1, OFS_FLAGS, 16'h0);
        rd_chk(OFS_FLAGS, 16'h0);
        bus(1'b1, OFS_EN, 16'h00e0);
        bus(1'b1, OFS_PRIO + 8'h4, 16'h0030);
        pulse(20'h0, 29'h80);
        quiet();
        pulse(20'h0, 29'h20);
        wait_req({1'b1, 4'h3, 6'd13}, 24'h00001e);
        wait_lvl(4'h3);
        bus(1'b1, OFS_PRIO + 8'h4, 16'h0630);
        bus(1'b1, OFS_CTRL1, 16'h8000);
        pulse(20'h0, 29'h40);
        quiet();
        bus(1'b1, OFS_LEVEL, 16'h0001);
        rd_chk(OFS_LEVEL, 16'h0003);
        bus(1'b1, OFS_CTRL1, 16'h0);
        wait_req({1'b1, 4'h6, 6'd14}, 24'h000020);
        bus(1'b1, OFS_FLAGS, 16'h0);
        wait_lvl(4'h0);
        $display("test priority done");
        bus(1'b1, OFS_LEVEL, 16'h0007);
        pulse(20'h0, 29'h20);
        quiet();
        pulse(20'h2, 29'h0);
        pulse(20'h400, 29'h0);
        wait_req({1'b1, 4'hc, 6'd2}, 24'h000008);
        bus(1'b1, OFS_FLAGS, 16'h0);
        wait_lvl(4'h7);
        bus(1'b1, OFS_LEVEL, 16'h0);
        $display("test traps done");
        bus(1'b1, OFS_CTRL1, 16'h0100);
        pulse(20'h30, 29'h0);
        rd_chk(OFS_CTRL1, 16'h0100);
        pulse(20'h10, 29'h0);
        rd_chk(OFS_CTRL1, 16'h0101);
        bus(1'b1, OFS_CTRL1, 16'h0);
        pulse(20'h4, 29'h0);
        pulse(20'h100, 29'h0);
        rd_chk(OFS_CTRL1, 16'h0005);
        bus(1'b1, OFS_CTRL2, 16'h8000);
        bus(1'b1, OFS_WIN, 16'h0001);
        pulse(20'h0, 29'h40);
        quiet();
        rd_chk(OFS_CTRL2, 16'hc000);
        pulse(20'h800, 29'h0);
        wait_req({1'b1, 4'h6, 6'd14}, 24'h0000a0);
        bus(1'b1, OFS_FLAGS, 16'h0);
        pulse(20'h3000, 29'h0);
        @(negedge clk);
        check(dev_reset_req, 1'b0);
        rd_chk(OFS_RCAUSE, 16'h0);
        pulse(20'h8000, 29'h0);
        @(negedge clk);
        check(dev_reset_req, 1'b1);
        pulse(20'h4000, 29'h0);
        pulse(20'h10000, 29'h0);
        pulse(20'h3, 29'h0);
        rd_chk(OFS_RCAUSE, 16'h001b);
        $display("test status done");
        results();
    end
endmodule : testbench
`default_nettype wire
